//--- hdl/raiu_defs.vh
// Register offsets, field positions and reset values of the receive alarm interrupt unit
`ifndef RAIU_DEFS_VH
`define RAIU_DEFS_VH
// Register indexes; byte address is four times the index
`define RAIU_IDX_LINE_STAT 5'h00
`define RAIU_IDX_PATH_STAT 5'h01
`define RAIU_IDX_OVF_STAT 5'h02
`define RAIU_IDX_LINE_MASK 5'h07
`define RAIU_IDX_PATH_MASK 5'h08
`define RAIU_IDX_OVF_MASK 5'h09
`define RAIU_IDX_ENABLE 5'h1c
`define RAIU_IDX_PEND 5'h1d
`define RAIU_IDX_CLEAR 5'h1e
// Reset values
`define RAIU_MASK_RST 8'h00
`define RAIU_ENABLE_RST 8'h01
// line_alarm_status fields
`define RAIU_B1_PAR 0
`define RAIU_B2_PAR 1
`define RAIU_B3_PAR 2
`define RAIU_CELL_LOST 3
`define RAIU_SIG_ABSENT 4
`define RAIU_FRAME_SLIP 5
`define RAIU_FRAME_LOST 6
`define RAIU_CARRIER_LOST 7
// path_alarm_status fields
`define RAIU_LINE_AIS 0
`define RAIU_LINE_FERF 1
`define RAIU_RX_OVF 2
`define RAIU_PTR_MISSING 3
`define RAIU_PATH_AIS 4
`define RAIU_B1_BLK_OVF 5
`define RAIU_B2_BLK_OVF 6
`define RAIU_B3_BLK_OVF 7
// counter_overflow_status fields
`define RAIU_B1_CV_OVF 0
`define RAIU_B2_CV_OVF 1
`define RAIU_B3_CV_OVF 2
`define RAIU_PATH_RDI 3
`define RAIU_PATH_FERF 4
// Sticky bits per register, other used bits are level bits; RAIU_USED3 lists the used overflow bits
`define RAIU_STICKY1 8'h07
`define RAIU_STICKY2 8'he0
`define RAIU_STICKY3 8'h07
`define RAIU_USED3 8'h1f
`endif

//--- hdl/raiu_top.v
// Receive alarm interrupt unit: alarm status, masks and active-low interrupt
// Summary of operation
// - Line status: parity, cell, signal, frame, carrier bits
// - Path and overflow status bit layout
// - External alarm status bits mirror alarm inputs
// - Any external alarm change asserts interrupt
// - Reads keep level bits; status read releases irq_out_n, irq waits for a clear write
// - Carrier, path AIS, RDI level bits, edge interrupt
// - Error bits sticky until any status read
// - Parity error sets bit and asserts interrupt
// - Cleared sticky bit stays clear until recurrence
// - Mask bit one blocks matching cause
// - Masks reset to zero
// - Status registers readable at indexes zero to two
// - Counter overflow sets bit and interrupts
`timescale 1ns/100ps
`include "raiu_defs.vh"
module raiu_top (
    input wire sys_clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [6:2] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire signal_absent_alarm,
    input wire framing_slip_alarm,
    input wire frame_lost_alarm,
    input wire line_alarm_indication,
    input wire pointer_missing_alarm,
    input wire line_far_end_fail,
    input wire cell_delineation_lost,
    input wire rx_fifo_overflow_alarm,
    input wire carrier_lost_alarm,
    input wire path_ais_alarm,
    input wire path_rdi_alarm,
    input wire path_ferf_alarm,
    input wire [2:0] parity_err_pulse,
    input wire [2:0] blk_ovf_pulse,
    input wire [2:0] cv_ovf_pulse,
    output wire irq_out_n,
    output wire irq
);

    // Alarm levels and error pulses come from pins: two synchroniser flops each
    reg [11:0] lvl_s1_r;
    reg [11:0] lvl_s2_r;
    reg [8:0] evt_s1_r;
    reg [8:0] evt_s2_r;
    reg [8:0] evt_d_r;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_s1_r <= 12'h000;
            lvl_s2_r <= 12'h000;
            evt_s1_r <= 9'h000;
            evt_s2_r <= 9'h000;
            evt_d_r <= 9'h000;
        end else begin
            lvl_s1_r <= {path_ferf_alarm, path_rdi_alarm, path_ais_alarm, carrier_lost_alarm,
                         rx_fifo_overflow_alarm, cell_delineation_lost, line_far_end_fail,
                         pointer_missing_alarm, line_alarm_indication, frame_lost_alarm,
                         framing_slip_alarm, signal_absent_alarm};
            lvl_s2_r <= lvl_s1_r;
            evt_s1_r <= {cv_ovf_pulse, blk_ovf_pulse, parity_err_pulse};
            evt_s2_r <= evt_s1_r;
            evt_d_r <= evt_s2_r;
        end
    end

    // Error events are rising edges of the synchronised pulses
    wire [8:0] evt_rise = evt_s2_r & ~evt_d_r;

    // Level bits placed in register layout
    wire [7:0] lvl1 = {lvl_s2_r[8], lvl_s2_r[2], lvl_s2_r[1], lvl_s2_r[0], lvl_s2_r[6], 3'h0};
    // Line AIS sits in bit 0 and pointer loss in bit 3
    wire [7:0] lvl2 = {3'h0, lvl_s2_r[9], lvl_s2_r[4], lvl_s2_r[7], lvl_s2_r[5], lvl_s2_r[3]};
    wire [7:0] lvl3 = {3'h0, lvl_s2_r[11], lvl_s2_r[10], 3'h0};
    // Sticky sets in register layout
    wire [7:0] set1 = {5'h00, evt_rise[2:0]};
    wire [7:0] set2 = {evt_rise[5:3], 5'h00};
    wire [7:0] set3 = {5'h00, evt_rise[8:6]};

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire bus_rd = bus_req & ~wb_we_i;
    wire [4:0] idx = wb_adr_i;
    wire stat_rd = bus_rd && (idx == `RAIU_IDX_LINE_STAT || idx == `RAIU_IDX_PATH_STAT ||
                              idx == `RAIU_IDX_OVF_STAT);

    reg [7:0] stat1_r;
    reg [7:0] stat2_r;
    reg [7:0] stat3_r;
    reg [7:0] mask1_r;
    reg [7:0] mask2_r;
    reg [7:0] mask3_r;
    reg [7:0] pend_r;
    reg [7:0] enable_r;
    reg irq_hold_r;

    // Sticky bits: a new error wins over a same-cycle read clear
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat1_r <= 8'h00;
            stat2_r <= 8'h00;
            stat3_r <= 8'h00;
        end else begin
            stat1_r <= lvl1 | set1 | (stat1_r & `RAIU_STICKY1 & {8{~stat_rd}});
            stat2_r <= lvl2 | set2 | (stat2_r & `RAIU_STICKY2 & {8{~stat_rd}});
            stat3_r <= lvl3 | set3 | (stat3_r & `RAIU_STICKY3 & {8{~stat_rd}});
        end
    end

    // Causes: level bits on either edge, sticky bits on their setting event
    wire [7:0] chg1 = ((lvl1 ^ stat1_r) & ~`RAIU_STICKY1) | set1;
    wire [7:0] chg2 = ((lvl2 ^ stat2_r) & ~`RAIU_STICKY2) | set2;
    wire [7:0] chg3 = ((lvl3 ^ stat3_r) & ~`RAIU_STICKY3 & `RAIU_USED3) | set3;
    wire cause = |(chg1 & ~mask1_r) | |(chg2 & ~mask2_r) | |(chg3 & ~mask3_r);

    // Interrupt latch; a cause in the read cycle keeps it asserted
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_hold_r <= 1'b0;
        end else if (cause) begin
            irq_hold_r <= 1'b1;
        end else if (stat_rd) begin
            irq_hold_r <= 1'b0;
        end
    end

    // Sticky pending bit for the system-level interrupt wrapper
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 8'h00;
        end else begin
            pend_r <= {7'h00, cause | (pend_r[0] &
                       ~(bus_wr && idx == `RAIU_IDX_CLEAR && wb_dat_i[0]))};
        end
    end

    // Register writes and bus answer one cycle after request
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask1_r <= `RAIU_MASK_RST;
            mask2_r <= `RAIU_MASK_RST;
            mask3_r <= `RAIU_MASK_RST;
            enable_r <= `RAIU_ENABLE_RST;
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_wr) begin
                if (idx == `RAIU_IDX_LINE_MASK) begin
                    mask1_r <= wb_dat_i[7:0];
                end else if (idx == `RAIU_IDX_PATH_MASK) begin
                    mask2_r <= wb_dat_i[7:0];
                end else if (idx == `RAIU_IDX_OVF_MASK) begin
                    mask3_r <= wb_dat_i[7:0];
                end else if (idx == `RAIU_IDX_ENABLE) begin
                    enable_r <= {7'h00, wb_dat_i[0]};
                end
            end
        end
    end

    // Read data; status read returns value before its clear
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_rd) begin
            if (idx == `RAIU_IDX_LINE_STAT) begin
                wb_dat_o <= {24'h000000, stat1_r};
            end else if (idx == `RAIU_IDX_PATH_STAT) begin
                wb_dat_o <= {24'h000000, stat2_r};
            end else if (idx == `RAIU_IDX_OVF_STAT) begin
                wb_dat_o <= {24'h000000, stat3_r};
            end else if (idx == `RAIU_IDX_LINE_MASK) begin
                wb_dat_o <= {24'h000000, mask1_r};
            end else if (idx == `RAIU_IDX_PATH_MASK) begin
                wb_dat_o <= {24'h000000, mask2_r};
            end else if (idx == `RAIU_IDX_OVF_MASK) begin
                wb_dat_o <= {24'h000000, mask3_r};
            end else if (idx == `RAIU_IDX_ENABLE) begin
                wb_dat_o <= {24'h000000, enable_r};
            end else if (idx == `RAIU_IDX_PEND) begin
                wb_dat_o <= {24'h000000, pend_r};
            end else begin
                wb_dat_o <= 32'h0000_0000; // Unmapped reads zero
            end
        end
    end

    // irq_out_n comes straight from a flop; irq is the AND of two flops, pend_r[0] and enable_r[0]
    assign irq_out_n = ~irq_hold_r;
    assign irq = pend_r[0] & enable_r[0];

endmodule // raiu_top

//--- sim/raiu_alarm_src.sv
// Alarm source standing in for the receive framer
`timescale 1ns/100ps
module raiu_alarm_src (
    input wire sys_clk,
    input wire [20:0] req,
    output reg [20:0] drv
);
    // Launched from the clock so alarm edges never race the synchronisers
    initial drv = 21'h000000;
    always @(posedge sys_clk) begin
        drv <= req;
    end
endmodule // raiu_alarm_src

//--- sim/raiu_chk.sv
// Checker of bus handshake and interrupt release at the unit's ports
`timescale 1ns/100ps
module raiu_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [6:2] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire irq_out_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Status read being taken at this edge
    wire stat_rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i <= 5'h02;
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_answer: assert property (s_take |=> s_answer)
        else $error("ack not a single pulse after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack while bus idle");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 5'h02 && wb_adr_i < 5'h07 |-> wb_dat_o == 0)
        else $error("unmapped read not zero");
    a_irq_hold: assert property (!irq_out_n && !stat_rd |=> !irq_out_n)
        else $error("interrupt released without status read");
    a_irq_release: assert property ($rose(irq_out_n) |-> wb_ack_o && !wb_we_i && wb_adr_i <= 5'h02)
        else $error("interrupt released off a status read ack");
endmodule // raiu_chk

//--- sim/testbench.sv
// Self-checking bench of the receive alarm interrupt unit
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
    reg sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    reg [4:0] adr = 0;
    reg [31:0] wdat = 0;
    reg [20:0] req = 0;
    reg [7:0] q;
    wire [20:0] al;
    wire [31:0] rdat;
    wire ack, irq_n, irq;
    int fail_count = 0, comparisons = 0, cycles = 0;
    // Status place of each alarm as index*8+bit: levels, then parity, block and CV pulses
    int loc [21] = '{4, 5, 6, 8, 11, 9, 3, 10, 7, 12, 19, 20, 0, 1, 2, 13, 14, 15, 16, 17, 18};
    initial forever #20 sys_clk = ~sys_clk;
    raiu_alarm_src u_src (.sys_clk(sys_clk), .req(req), .drv(al));
    raiu_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .signal_absent_alarm(al[0]), .framing_slip_alarm(al[1]), .frame_lost_alarm(al[2]),
        .line_alarm_indication(al[3]), .pointer_missing_alarm(al[4]), .line_far_end_fail(al[5]),
        .cell_delineation_lost(al[6]), .rx_fifo_overflow_alarm(al[7]), .carrier_lost_alarm(al[8]),
        .path_ais_alarm(al[9]), .path_rdi_alarm(al[10]), .path_ferf_alarm(al[11]),
        .parity_err_pulse(al[14:12]), .blk_ovf_pulse(al[17:15]), .cv_ovf_pulse(al[20:18]),
        .irq_out_n(irq_n), .irq(irq));
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Classic cycle; ack is seen at the edge after the one that registered it, before it drops
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do @(posedge sys_clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // One-cycle error event, then the three edges it needs to reach the interrupt
    task automatic pulse(input int i);
        @(posedge sys_clk);
        req[i] <= 1'b1;
        @(posedge sys_clk);
        req[i] <= 1'b0;
        wt(3);
    endtask
    task automatic t_reset;
        `CHK("irq_out_n", 1'b1, irq_n)
        for (int a = 7; a <= 9; a++) begin
            bus(0, 5'(a), 8'h00);
            `CHK("mask reset", 8'h00, q)
        end
        bus(1, 5'h00, 8'hff);
        bus(0, 5'h00, 8'h00);
        `CHK("status write", 8'h00, q)
        bus(0, 5'h05, 8'h00);
        `CHK("unmapped", 8'h00, q)
        $display("reset test done");
    endtask
    task automatic t_level;
        logic [7:0] m;
        for (int i = 0; i < 12; i++) begin
            m = 8'h01 << (loc[i] % 8);
            req[i] <= 1'b1;
            wt(4);
            `CHK("irq on rise", 1'b0, irq_n)
            bus(0, 5'(loc[i] / 8), 8'h00);
            `CHK("level set", m, q)
            #1;
            `CHK("release", 1'b1, irq_n)
            bus(0, 5'(loc[i] / 8), 8'h00);
            `CHK("level kept", m, q)
            req[i] <= 1'b0;
            wt(4);
            `CHK("irq on fall", 1'b0, irq_n)
            bus(0, 5'(loc[i] / 8), 8'h00);
            `CHK("level clear", 8'h00, q)
        end
        $display("level test done");
    endtask
    task automatic t_sticky;
        logic [4:0] r;
        for (int i = 12; i < 21; i++) begin
            r = 5'(loc[i] / 8);
            pulse(i);
            `CHK("irq on error", 1'b0, irq_n)
            bus(0, r, 8'h00);
            `CHK("sticky set", 8'h01 << (loc[i] % 8), q)
            pulse(i);
            `CHK("system irq", 1'b1, irq)
            bus(0, (r == 5'h00) ? 5'h02 : 5'h00, 8'h00);
            bus(0, r, 8'h00);
            `CHK("sticky cleared", 8'h00, q)
        end
        bus(1, 5'h1c, 8'h00);
        #1;
        `CHK("irq disabled", 1'b0, irq)
        bus(1, 5'h1e, 8'h01);
        bus(0, 5'h1d, 8'h00);
        `CHK("pending cleared", 8'h00, q)
        bus(1, 5'h1c, 8'h01);
        $display("sticky test done");
    endtask
    task automatic t_mask;
        bus(1, 5'h07, 8'h10);
        bus(0, 5'h07, 8'h00);
        `CHK("mask rw", 8'h10, q)
        req[0] <= 1'b1;
        wt(4);
        `CHK("masked irq", 1'b1, irq_n)
        bus(0, 5'h00, 8'h00);
        `CHK("masked status", 8'h10, q)
        req[0] <= 1'b0;
        req[1] <= 1'b1;
        wt(4);
        `CHK("unmasked irq", 1'b0, irq_n)
        $display("mask test done");
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        wt(1);
        t_reset;
        t_level;
        t_sticky;
        t_mask;
        give_verdict;
    end
    // Cuts a hang short well past the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            give_verdict;
        end
    end
endmodule // testbench
bind raiu_top raiu_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_out_n(irq_out_n));
